//--- logic/rtcfi_params.svh
// Register offsets, field positions, reset values and timing counts of the flag block.
`ifndef RTCFI_PARAMS_SVH
`define RTCFI_PARAMS_SVH
`define RTCFI_CLK_HZ          40000000
`define RTCFI_ADDR_W          13
`define RTCFI_OFF_FLAGS       13'h1ff0
`define RTCFI_OFF_ALARM       13'h1ff6
`define RTCFI_OFF_WDOG        13'h1ff7
`define RTCFI_OFF_DAY         13'h1ffc
`define RTCFI_OFF_CTRL        13'h1ff8
`define RTCFI_OFF_ISTAT       13'h1fe0
`define RTCFI_OFF_IMASK       13'h1fe1
`define RTCFI_OFF_MISC        13'h1fe2
`define RTCFI_BIT_AF          6
`define RTCFI_BIT_WDF         7
`define RTCFI_BIT_BL          4
`define RTCFI_BIT_AFE         7
`define RTCFI_BIT_ABE         5
`define RTCFI_BIT_WDS         7
`define RTCFI_BIT_FT          6
`define RTCFI_BIT_CEB         5
`define RTCFI_BIT_CB          4
`define RTCFI_BIT_UPD_LOCK    7
`define RTCFI_BIT_SNAP        6
`define RTCFI_WDOG_RESET      8'h00
`define RTCFI_FLAG_HOLD_NS    15
`define RTCFI_FLAG_HOLD_CYC   ((`RTCFI_FLAG_HOLD_NS * 40 + 999) / 1000)
`define RTCFI_WDRST_CYC       8
`define RTCFI_FT_HALF_CYC     39062
`endif

//--- logic/rtcfi_pkg.sv
// Types shared by the flag and interrupt block.
package rtcfi_pkg;
  typedef struct packed {
    logic       read;
    logic       write;
    logic [12:0] address;
    logic [7:0] writedata;
  } rtcfi_req_t;
  typedef struct packed {
    logic alarm_match;
    logic wdog_timeout;
    logic day_rollover;
    logic century_rollover;
    logic batt_low;
    logic power_up;
    logic power_down;
    logic backup_mode;
  } rtcfi_evt_t;
  typedef enum logic [1:0] {
    RTCFI_IDLE = 2'b00,
    RTCFI_HOLD = 2'b01,
    RTCFI_DONE = 2'b10
  } rtcfi_bus_t;
endpackage

//--- logic/rtcfi_pulse.sv
// Fixed-length high pulse generator, inverted by the core for the watchdog reset output.
`timescale 1ns/1ps
module rtcfi_pulse #(
  parameter int LEN = 8
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Trigger and output
  input  wire logic i_start,
  output logic      o_pulse
);
  initial begin
    if (LEN < 1 || LEN > 255) $error("rtcfi_pulse: LEN out of range");
  end
  logic [7:0] cnt;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= 8'h00;
    end else if (i_start) begin
      cnt <= 8'(LEN);
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= i_start || (cnt > 8'h01);
    end
  end
endmodule

//--- logic/rtcfi_divider.sv
// Free-running toggle used as the frequency test square wave.
`timescale 1ns/1ps
module rtcfi_divider #(
  parameter int HALF = 39062
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Square wave
  output logic      o_wave
);
  initial begin
    if (HALF < 1 || HALF > 65535) $error("rtcfi_divider: HALF out of range");
  end
  logic [15:0] cnt;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt    <= 16'h0000;
      o_wave <= 1'b0;
    end else if (cnt == 16'(HALF - 1)) begin
      cnt    <= 16'h0000;
      o_wave <= ~o_wave;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

//--- logic/rtcfi_core.sv
// Flags, interrupt pin, battery-low and century logic behind an Avalon-MM slave.
//
// Summary of operation
// R1: Alarm match or watchdog timeout sets its flag in the flags register.
// R2: Interrupt pin asserts only if alarm enables or watchdog steering permit it.
// R3: Reading the flags register clears the alarm flag and releases the pin.
// R4: Host holds the flags address in read mode at least 15 ns to clear.
// R5: Interrupt pin is open drain, driven only for interrupt or frequency test.
// R6: Battery tested at power-up and at each day rollover, with main power present.
// R7: Failed battery test sets battery-low flag, bit four of the flags register.
// R8: Battery-low stays set until a later test passes.
// R9: No battery tests while in back-up mode.
// R10: Century bit inverts at century rollover when its enable is one.
// R11: Century bit writes take effect only while the update lock is set.
// R12: Power application clears steering, timeout, alarm enables, lock, snapshot, test bits.
// R13: Other control bits keep previous values across later power-ups.
// R14: Power-down clears lock, snapshot, test bit and watchdog; alarm enables kept.
// R15: Steering zero routes timeout to the interrupt; one gives a reset pulse.
// R16: In back-up mode an alarm pulls the pin only with both alarm enables.
// R17: Reading the flags register also clears the watchdog expired flag.
// R18: Host must change address before a changed flag shows on a read.
// R19: Interrupt stays asserted while an enabled flag remains uncleared.
//
// Chosen here: register access over Avalon-MM.
`include "rtcfi_params.svh"
`timescale 1ns/1ps
module rtcfi_core #(
  parameter int FT_HALF  = `RTCFI_FT_HALF_CYC,
  parameter int RST_LEN  = `RTCFI_WDRST_CYC
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // Avalon-MM slave
  input  wire logic [`RTCFI_ADDR_W-1:0]   i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [7:0]                 i_avs_writedata,
  output logic      [7:0]                 o_avs_readdata,
  output logic                            o_avs_waitrequest,
  // Timekeeping events and supply state
  input  wire rtcfi_pkg::rtcfi_evt_t      i_evt,
  // Pins and interrupt
  output logic                            o_interrupt_or_test_pin_out,
  output logic                            o_interrupt_or_test_pin_oe_n,
  output logic                            o_wdog_reset_n,
  output logic                            o_irq
);
  initial begin
    if (FT_HALF < 1 || RST_LEN < 1) $error("rtcfi_core: bad parameter");
  end

  rtcfi_pkg::rtcfi_req_t req;
  rtcfi_pkg::rtcfi_bus_t bstate;
  logic [7:0] flags;
  logic [7:0] alarm_reg;
  logic [7:0] wdog_reg;
  logic [7:0] day_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] istat;
  logic [7:0] imask;
  logic [1:0] hold_cnt;
  logic       flags_read;
  logic       wd_pulse;
  logic       ft_wave;
  logic       pin_low;
  logic       wd_steer;
  logic       next_pin_low;
  logic       bus_cycle;
  logic       wr_ok;
  logic       pup;
  logic       pdn;

  assign req       = '{read: i_avs_read, write: i_avs_write,
                       address: i_avs_address, writedata: i_avs_writedata};
  assign pup       = i_evt.power_up;
  assign pdn       = i_evt.power_down;
  assign bus_cycle = (bstate == rtcfi_pkg::RTCFI_HOLD) &&
                     (hold_cnt > 2'(`RTCFI_FLAG_HOLD_CYC));
  assign wr_ok     = bus_cycle && req.write;
  // A flags read counts only after the address has stood for the hold time.
  assign flags_read = bus_cycle && req.read && (req.address == `RTCFI_OFF_FLAGS); // R4 R3

  // Bus sequencer: a request is held, answered once, then released.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bstate   <= rtcfi_pkg::RTCFI_IDLE;
      hold_cnt <= 2'h0;
    end else begin
      unique case (bstate)
        rtcfi_pkg::RTCFI_IDLE: begin
          hold_cnt <= 2'h1;
          if (req.read || req.write) begin
            bstate <= rtcfi_pkg::RTCFI_HOLD;
          end
        end
        rtcfi_pkg::RTCFI_HOLD: begin
          if (bus_cycle) begin
            bstate <= rtcfi_pkg::RTCFI_DONE;
          end else begin
            hold_cnt <= hold_cnt + 2'h1;
          end
        end
        rtcfi_pkg::RTCFI_DONE: begin
          bstate <= rtcfi_pkg::RTCFI_IDLE;
        end
        default: begin
          bstate <= rtcfi_pkg::RTCFI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((bstate == rtcfi_pkg::RTCFI_HOLD) &&
                             (hold_cnt + 2'h1 >= 2'(`RTCFI_FLAG_HOLD_CYC)) &&
                             !bus_cycle) ;
    end
  end

  // Read data is captured at request time; a flag change appears only on the next access.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 8'h00;
    end else if ((bstate == rtcfi_pkg::RTCFI_HOLD) && req.read && !bus_cycle) begin // R18
      unique case (req.address)
        `RTCFI_OFF_FLAGS: o_avs_readdata <= flags;
        `RTCFI_OFF_ALARM: o_avs_readdata <= alarm_reg;
        `RTCFI_OFF_WDOG:  o_avs_readdata <= wdog_reg;
        `RTCFI_OFF_DAY:   o_avs_readdata <= day_reg;
        `RTCFI_OFF_CTRL:  o_avs_readdata <= ctrl_reg;
        `RTCFI_OFF_ISTAT: o_avs_readdata <= istat;
        `RTCFI_OFF_IMASK: o_avs_readdata <= imask;
        default:          o_avs_readdata <= 8'h00;
      endcase
    end
  end

  // Flags register: hardware sets win over the read clear.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags <= 8'h00;
    end else begin
      flags[`RTCFI_BIT_AF] <= i_evt.alarm_match ||
                              (flags[`RTCFI_BIT_AF] && !flags_read); // R1 R3
      flags[`RTCFI_BIT_WDF] <= (i_evt.wdog_timeout && wdog_reg != 8'h00) ||
                               (flags[`RTCFI_BIT_WDF] && !flags_read); // R1 R17
      // Battery test only with main power: at power-up and at day rollover.
      if ((pup || i_evt.day_rollover) && !i_evt.backup_mode) begin // R6 R9
        flags[`RTCFI_BIT_BL] <= i_evt.batt_low; // R7 R8
      end
    end
  end

  // A steered timeout clears the watchdog register at once, so the route is remembered here.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wd_steer <= 1'b0;
    end else begin
      wd_steer <= (i_evt.wdog_timeout && wdog_reg != 8'h00 && !wdog_reg[`RTCFI_BIT_WDS]) ||
                  (wd_steer && !flags_read); // R15 R17
    end
  end

  // Alarm enables: cleared on power application, kept across power-down.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      alarm_reg <= 8'h00;
    end else if (pup) begin
      alarm_reg[`RTCFI_BIT_AFE] <= 1'b0; // R12
      alarm_reg[`RTCFI_BIT_ABE] <= 1'b0; // R12
    end else if (i_evt.wdog_timeout && wdog_reg[`RTCFI_BIT_WDS]) begin
      alarm_reg[`RTCFI_BIT_AFE] <= 1'b0;
      alarm_reg[`RTCFI_BIT_ABE] <= 1'b0;
    end else if (wr_ok && req.address == `RTCFI_OFF_ALARM) begin
      alarm_reg <= req.writedata; // R14 R13
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wdog_reg <= `RTCFI_WDOG_RESET;
    end else if (pup || pdn) begin
      wdog_reg <= `RTCFI_WDOG_RESET; // R12 R14
    end else if (i_evt.wdog_timeout && wdog_reg[`RTCFI_BIT_WDS]) begin
      wdog_reg <= `RTCFI_WDOG_RESET;
    end else if (wr_ok && req.address == `RTCFI_OFF_WDOG) begin
      wdog_reg <= req.writedata;
    end
  end

  // Control register holds the update lock and the read snapshot bit.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= 8'h00;
    end else if (pup || pdn) begin
      ctrl_reg[`RTCFI_BIT_UPD_LOCK] <= 1'b0; // R12 R14
      ctrl_reg[`RTCFI_BIT_SNAP]     <= 1'b0; // R12 R14
    end else if (wr_ok && req.address == `RTCFI_OFF_CTRL) begin
      ctrl_reg <= req.writedata; // R13
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      day_reg <= 8'h00;
    end else begin
      if (wr_ok && req.address == `RTCFI_OFF_DAY) begin
        day_reg <= {req.writedata[7:5], day_reg[4], req.writedata[3:0]};
        if (ctrl_reg[`RTCFI_BIT_UPD_LOCK]) begin
          day_reg[`RTCFI_BIT_CB] <= req.writedata[`RTCFI_BIT_CB]; // R11
        end
      end else if (i_evt.century_rollover && day_reg[`RTCFI_BIT_CEB]) begin
        day_reg[`RTCFI_BIT_CB] <= ~day_reg[`RTCFI_BIT_CB]; // R10
      end
      if (pup || pdn) begin
        day_reg[`RTCFI_BIT_FT] <= 1'b0; // R12 R14
      end else if (i_evt.wdog_timeout && wdog_reg[`RTCFI_BIT_WDS]) begin
        day_reg[`RTCFI_BIT_FT] <= 1'b0;
      end
    end
  end

  // Pin decision: an enabled interrupt prevails over frequency test.
  always_comb begin
    logic alarm_ok;
    logic wd_irq;
    logic ft_on;
    alarm_ok = alarm_reg[`RTCFI_BIT_AFE] &&
               (!i_evt.backup_mode || alarm_reg[`RTCFI_BIT_ABE]); // R2 R16
    wd_irq   = flags[`RTCFI_BIT_WDF] && wd_steer; // R15
    ft_on    = day_reg[`RTCFI_BIT_FT] && !alarm_reg[`RTCFI_BIT_AFE] &&
               (wdog_reg[`RTCFI_BIT_WDS] || wdog_reg == 8'h00);
    next_pin_low = (flags[`RTCFI_BIT_AF] && alarm_ok) || wd_irq; // R19
    if (!next_pin_low && ft_on && !i_evt.backup_mode) begin
      next_pin_low = !ft_wave; // R5
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_low                     <= 1'b0;
      o_interrupt_or_test_pin_out <= 1'b0;
      o_interrupt_or_test_pin_oe_n <= 1'b1;
    end else begin
      pin_low                      <= next_pin_low;
      o_interrupt_or_test_pin_out  <= 1'b0;
      o_interrupt_or_test_pin_oe_n <= !next_pin_low; // R5
    end
  end

  // Sticky status, cleared by reading it; a new event wins over the clear.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      istat <= 8'h00;
    end else begin
      istat <= {i_evt.wdog_timeout, i_evt.alarm_match, 1'b0,
                (pup || i_evt.day_rollover) && i_evt.batt_low && !i_evt.backup_mode,
                1'b0, 1'b0, i_evt.century_rollover, 1'b0} |
               (istat & {8{!(bus_cycle && req.read && req.address == `RTCFI_OFF_ISTAT)}});
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      imask <= 8'h00;
    end else if (wr_ok && req.address == `RTCFI_OFF_IMASK) begin
      imask <= req.writedata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(istat & imask);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wdog_reset_n <= 1'b1;
    end else begin
      o_wdog_reset_n <= !wd_pulse;
    end
  end

  rtcfi_pulse #(.LEN(RST_LEN)) u_pulse (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (i_evt.wdog_timeout && wdog_reg[`RTCFI_BIT_WDS] && !pdn), // R15
    .o_pulse (wd_pulse)
  );

  rtcfi_divider #(.HALF(FT_HALF)) u_div (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_wave  (ft_wave)
  );
endmodule

//--- sim/rtcfi_core_asserts.sv
// Port-level checks of the flag and interrupt block.
`include "rtcfi_params.svh"
`timescale 1ns/1ps
module rtcfi_chk #(
  parameter int RST_LEN = 8
) (
  // Clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_rst_n,
  // Register bus
  input wire logic [`RTCFI_ADDR_W-1:0] i_avs_address,
  input wire logic                     i_avs_read,
  input wire logic                     i_avs_write,
  input wire logic [7:0]               i_avs_writedata,
  input wire logic [7:0]               o_avs_readdata,
  input wire logic                     o_avs_waitrequest,
  // Events
  input wire rtcfi_pkg::rtcfi_evt_t i_evt,
  // Pins
  input wire logic o_interrupt_or_test_pin_out,
  input wire logic o_interrupt_or_test_pin_oe_n,
  input wire logic o_wdog_reset_n,
  input wire logic o_irq
);
  logic acc;
  logic hit;
  logic clr;
  logic ft_on;
  int   low_cnt;
  assign acc = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
  assign hit = i_evt.alarm_match | i_evt.wdog_timeout;
  // Reading the mask is counted too; that only weakens the check, never fires it.
  assign clr = acc & (i_avs_address == `RTCFI_OFF_ISTAT | i_avs_address == `RTCFI_OFF_IMASK);
  // The test square wave also pulls the pin, so the pin cause and clear checks stand aside while it may run.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ft_on <= 1'b0;
    end else if (acc && i_avs_write && i_avs_address == `RTCFI_OFF_DAY) begin
      ft_on <= i_avs_writedata[`RTCFI_BIT_FT];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || o_wdog_reset_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_WAIT_TWO: assert property (
    $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not on second edge");
  AST_WAIT_ONE: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  AST_PIN_ZERO: assert property (
    o_interrupt_or_test_pin_out == 1'b0)
    else $error("pin drives high");
  AST_PIN_CAUSE: assert property (
    $fell(o_interrupt_or_test_pin_oe_n) && !ft_on && !$past(ft_on)
      |-> $past(hit, 1) || $past(hit, 2) || $past(hit, 3))
    else $error("pin pulled without event");
  AST_PIN_CLEAR: assert property (
    acc && i_avs_read && i_avs_address == `RTCFI_OFF_FLAGS && !ft_on
      |-> ##2 o_interrupt_or_test_pin_oe_n)
    else $error("pin kept after flags read");
  AST_IRQ_FALL: assert property (
    $fell(o_irq) |-> $past(clr, 1) || $past(clr, 2))
    else $error("irq dropped without clear");
  AST_WDRST_LEN: assert property (
    $rose(o_wdog_reset_n) |-> low_cnt == RST_LEN)
    else $error("reset pulse length wrong");
  AST_WDRST_CAUSE: assert property (
    $fell(o_wdog_reset_n) |-> $past(i_evt.wdog_timeout, 1) || $past(i_evt.wdog_timeout, 2))
    else $error("reset pulse without timeout");
endmodule
bind rtcfi_core rtcfi_chk #(.RST_LEN(RST_LEN)) i_rtcfi_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_evt(i_evt),
  .o_interrupt_or_test_pin_out(o_interrupt_or_test_pin_out),
  .o_interrupt_or_test_pin_oe_n(o_interrupt_or_test_pin_oe_n),
  .o_wdog_reset_n(o_wdog_reset_n), .o_irq(o_irq));

//--- sim/rtcfi_host.sv
// Processor model that drives the register bus as an Avalon-MM master.
`include "rtcfi_params.svh"
`timescale 1ns/1ps
module rtcfi_host (
  // Clock
  input  wire logic                   i_clk,
  // Master side of the register bus
  output logic [`RTCFI_ADDR_W-1:0]    o_address,
  output logic                        o_read,
  output logic                        o_write,
  output logic [7:0]                  o_writedata,
  input  wire logic [7:0]             i_readdata,
  input  wire logic                   i_waitrequest
);
  initial begin
    o_address   = '0;
    o_read      = 1'b0;
    o_write     = 1'b0;
    o_writedata = '0;
  end
  // One transfer; ok stays low when no answer comes in time.
  task automatic xfer(input logic wr, input logic [12:0] a, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    ok = 1'b0;
    q  = 8'h00;
    @(posedge i_clk);
    o_address   <= a;
    o_writedata <= d;
    o_write     <= wr;
    o_read      <= ~wr;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge i_clk);
      if (!i_waitrequest) begin
        ok = 1'b1;
        q  = i_readdata;
      end
    end
    // Released address and data lines show inverted values so that a stale decode cannot pass.
    o_address   <= ~a;
    o_writedata <= ~d;
    o_read      <= 1'b0;
    o_write     <= 1'b0;
  endtask
endmodule

//--- sim/rtcfi_core_tb.sv
// Self-checking bench of the flag and interrupt block.
`include "rtcfi_params.svh"
`timescale 1ns/1ps
module rtcfi_core_tb;
  typedef struct packed {
    logic [12:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } rtcfi_row_t;
  localparam int RSTL = 8;
  logic                  clk;
  logic                  rst_n;
  logic [7:0]            pls;
  logic                  batt;
  logic                  bkup;
  rtcfi_pkg::rtcfi_evt_t evt;
  logic [12:0]           address;
  logic                  read;
  logic                  write;
  logic [7:0]            wdata;
  logic [7:0]            rdata;
  logic                  waitreq;
  logic                  oe_n;
  logic                  wd_rst_n;
  logic                  irq;
  int                    err_total = 0;
  int                    comparisons = 0;
  int                    lowc;
  rtcfi_row_t rows [8] = '{'{`RTCFI_OFF_CTRL, 8'h80, 8'h80}, '{`RTCFI_OFF_DAY, 8'h30, 8'h30},
    '{`RTCFI_OFF_CTRL, 8'h00, 8'h00}, '{`RTCFI_OFF_DAY, 8'h20, 8'h30},
    '{13'h1fff, 8'h5a, 8'h00}, '{`RTCFI_OFF_IMASK, 8'hd2, 8'hd2},
    '{`RTCFI_OFF_ALARM, 8'ha0, 8'ha0}, '{`RTCFI_OFF_WDOG, 8'h00, 8'h00}};
  rtcfi_row_t pr [4] = '{'{`RTCFI_OFF_ALARM, 8'ha0, 8'ha0}, '{`RTCFI_OFF_WDOG, 8'h05, 8'h00},
    '{`RTCFI_OFF_CTRL, 8'hc5, 8'h05}, '{`RTCFI_OFF_DAY, 8'h60, 8'h20}};
  assign evt = rtcfi_pkg::rtcfi_evt_t'(pls | {4'h0, batt, 2'b00, bkup});
  always #12.5 clk = ~clk;
  rtcfi_core #(.FT_HALF(4), .RST_LEN(RSTL)) i_rtcfi_core (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(address), .i_avs_read(read),
    .i_avs_write(write), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_evt(evt), .o_interrupt_or_test_pin_out(),
    .o_interrupt_or_test_pin_oe_n(oe_n), .o_wdog_reset_n(wd_rst_n), .o_irq(irq));
  rtcfi_host i_rtcfi_host (
    .i_clk(clk), .o_address(address), .o_read(read), .o_write(write),
    .o_writedata(wdata), .i_readdata(rdata), .i_waitrequest(waitreq));
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    bit ok;
    i_rtcfi_host.xfer(w, a, d, q, ok);
    if (!ok) begin
      err_total++;
      results();
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask
  // One-cycle event, then a settling window that also counts reset-pulse cycles.
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    pls <= m;
    @(posedge clk);
    pls <= 8'h00;
    lowc = 0;
    repeat (12) begin
      @(posedge clk);
      lowc += int'(!wd_rst_n);
    end
  endtask
  initial begin
    clk   = 1'b0;
    rst_n = 1'b0;
    pls   = 8'h00;
    batt  = 1'b0;
    bkup  = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({4'h0, waitreq, oe_n, wd_rst_n, irq}, 8'h0e);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rdc(rows[k].a, 8'hff, rows[k].e);
    end
    pulse(8'h10);
    rdc(`RTCFI_OFF_DAY, 8'h30, 8'h20);
    rdc(`RTCFI_OFF_ISTAT, 8'h02, 8'h02);
    wr(`RTCFI_OFF_DAY, 8'h00);
    pulse(8'h10);
    rdc(`RTCFI_OFF_DAY, 8'h30, 8'h00);
    wr(`RTCFI_OFF_IMASK, 8'h40);
    pulse(8'h80);
    chk({6'h0, oe_n, irq}, 8'h01);
    rdc(`RTCFI_OFF_FLAGS, 8'hc0, 8'h40);
    repeat (2) @(posedge clk);
    chk({6'h0, oe_n, irq}, 8'h03);
    rdc(`RTCFI_OFF_FLAGS, 8'hc0, 8'h00);
    rdc(`RTCFI_OFF_ISTAT, 8'h40, 8'h40);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(`RTCFI_OFF_ALARM, 8'h80);
    bkup <= 1'b1;
    pulse(8'h80);
    chk({7'h0, oe_n}, 8'h01);
    rdc(`RTCFI_OFF_FLAGS, 8'h40, 8'h40);
    bkup <= 1'b0;
    wr(`RTCFI_OFF_ALARM, 8'h00);
    pulse(8'h80);
    chk({7'h0, oe_n}, 8'h01);
    rdc(`RTCFI_OFF_FLAGS, 8'h40, 8'h40);
    wr(`RTCFI_OFF_WDOG, 8'h01);
    pulse(8'h40);
    chk({7'h0, oe_n}, 8'h00);
    rdc(`RTCFI_OFF_FLAGS, 8'hc0, 8'h80);
    rdc(`RTCFI_OFF_FLAGS, 8'hc0, 8'h00);
    chk({7'h0, oe_n}, 8'h01);
    wr(`RTCFI_OFF_WDOG, 8'h81);
    pulse(8'h40);
    chk(8'(lowc), 8'(RSTL));
    chk({7'h0, oe_n}, 8'h01);
    rdc(`RTCFI_OFF_FLAGS, 8'h40, 8'h00);
    batt <= 1'b1;
    pulse(8'h20);
    rdc(`RTCFI_OFF_FLAGS, 8'h10, 8'h10);
    batt <= 1'b0;
    bkup <= 1'b1;
    pulse(8'h20);
    bkup <= 1'b0;
    rdc(`RTCFI_OFF_FLAGS, 8'h10, 8'h10);
    pulse(8'h20);
    rdc(`RTCFI_OFF_FLAGS, 8'h10, 8'h00);
    batt <= 1'b1;
    pulse(8'h04);
    rdc(`RTCFI_OFF_FLAGS, 8'h10, 8'h10);
    batt <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      foreach (pr[k]) wr(pr[k].a, pr[k].d);
      pulse(p ? 8'h04 : 8'h02);
      foreach (pr[k]) rdc(pr[k].a, 8'hff, (p && k == 0) ? 8'h00 : pr[k].e);
    end
    wr(`RTCFI_OFF_DAY, 8'h40);
    lowc = 0;
    repeat (40) begin
      @(posedge clk);
      lowc += int'(!oe_n);
    end
    chk({7'h0, lowc inside {[14:26]}}, 8'h01);
    wr(`RTCFI_OFF_DAY, 8'h00);
    repeat (3) @(posedge clk);
    chk({7'h0, oe_n}, 8'h01);
    results();
  end
endmodule
